// File: dv/wgt_core_model.sv
`timescale 1ns/1ps
`default_nettype none
module wgt_core_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic go_i,
  input wire logic [3:0] dly_i,
  output logic clr_o
);
  logic busy_q;
  logic [3:0] cnt_q;
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      busy_q <= 1'b0;
      cnt_q <= 4'h0;
      clr_o <= 1'b0;
    end else begin
      // One cycle per instruction; arming read is the bench's job
      clr_o <= busy_q & (cnt_q == 4'h0);
      if (go_i) begin
        busy_q <= 1'b1;
        cnt_q <= dly_i;
      end else if (busy_q) begin
        busy_q <= (cnt_q != 4'h0);
        cnt_q <= cnt_q - 4'h1;
      end
    end
  end
endmodule
`default_nettype wire

// File: dv/wgt_guard_sva.sv
`timescale 1ns/1ps
`default_nettype none
module wgt_guard_chk (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  input wire logic [31:0] hrdata_o,
  input wire logic hreadyout_o,
  input wire logic hresp_o,
  input wire logic [1:0] guard_mode_cfg_i,
  input wire logic [2:0] cfg_window_i,
  input wire logic [2:0] cfg_window_select_i,
  input wire logic sleep_i,
  input wire logic guard_clear_instr_i,
  input wire logic guard_reset_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  // ----
  // Shadow state
  // ----
  logic wr1_q;
  logic armed_q;
  logic [2:0] win_q;
  logic [16:0] quiet_q;
  wire logic ap = hsel_i & htrans_i[1] & hready_i;
  wire logic m3 = (guard_mode_cfg_i == 2'b11);
  wire logic [2:0] win =
    (cfg_window_select_i == 3'h7) ? win_q : cfg_window_i;
  // Upper bound on the age of the design counter
  wire logic restart = guard_clear_instr_i | guard_reset_o |
    (ap & hwrite_i & (haddr_i[31:3] == 29'h0));
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      wr1_q <= 1'b0;
      armed_q <= 1'b0;
      win_q <= 3'h7;
      quiet_q <= 17'h0_0000;
    end else begin
      wr1_q <= ap & hwrite_i & (haddr_i == 32'h0000_0004);
      if (wr1_q) win_q <= hwdata_i[6:4];
      if (guard_clear_instr_i) armed_q <= 1'b0;
      else if (ap & ~hwrite_i & (haddr_i == 32'h0)) armed_q <= 1'b1;
      if (restart) quiet_q <= 17'h0_0000;
      else if (quiet_q != 17'h1_ffff) quiet_q <= quiet_q + 17'h0_0001;
    end
  end
  // ----
  // Properties
  // ----
  property p_off;
    (guard_mode_cfg_i == 2'b00) [*2] |-> !guard_reset_o;
  endproperty
  a_off: assert property (p_off) else $error("reset while off");
  property p_sleep;
    (guard_mode_cfg_i == 2'b10 && sleep_i) [*2] |-> !guard_reset_o;
  endproperty
  a_sleep: assert property (p_sleep) else $error("reset asleep");
  property p_viol;
    m3 && guard_clear_instr_i && !armed_q && win != 3'h7 |=> guard_reset_o;
  endproperty
  a_viol: assert property (p_viol) else $error("unarmed clear");
  // Under 80000 cycles the count is far below the top threshold
  property p_closed;
    m3 && guard_clear_instr_i && win == 3'h0 && quiet_q < 17'h1_3880
      |=> guard_reset_o;
  endproperty
  a_closed: assert property (p_closed) else $error("closed clear");
  // 96000 cycles: thirty ticks at the fastest time base
  property p_tmo;
    guard_reset_o && !$past(guard_clear_instr_i) |->
      $past(quiet_q) >= 17'h1_7700;
  endproperty
  a_tmo: assert property (p_tmo) else $error("early timeout");
  property p_pulse;
    guard_reset_o |=> !guard_reset_o;
  endproperty
  a_pulse: assert property (p_pulse) else $error("long pulse");
  property p_unmap;
    ap && !hwrite_i && haddr_i[31:8] != 24'h0 |=> hrdata_o == 32'h0;
  endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped data");
  property p_ok;
    ap |=> hreadyout_o && !hresp_o;
  endproperty
  a_ok: assert property (p_ok) else $error("bus response");
  c_viol: cover property (guard_clear_instr_i ##1 guard_reset_o);
  c_tmo: cover property (guard_reset_o && !$past(guard_clear_instr_i));
  c_unm: cover property (ap && haddr_i[31:8] != 24'h0);
endmodule
bind wgt_guard wgt_guard_chk u_chk (.clk_i, .rst_i, .hsel_i, .haddr_i,
  .htrans_i, .hwrite_i, .hwdata_i, .hready_i, .hrdata_o, .hreadyout_o,
  .hresp_o, .guard_mode_cfg_i, .cfg_window_i, .cfg_window_select_i,
  .sleep_i, .guard_clear_instr_i, .guard_reset_o);
`default_nettype wire

// File: dv/windowed_watchdog_timer_tb.sv
`timescale 1ns/1ps
`default_nettype none
module windowed_watchdog_timer_tb;
  logic clk_i, rst_i, hsel, hwrite, sleep, go, rd_dp, hready, hresp;
  logic clr, grst, irq, osc_startup_timer;
  logic [1:0] htrans, mode;
  logic [2:0] cclk, cwin, wsel;
  logic [3:0] dly;
  logic [4:0] cper;
  logic [6:0] c;
  logic [31:0] haddr, hwdata, hrdata, r;
  logic [31:0] exp_q[$];
  int err_count, n_compared, n_rst, i;
  // Mode, sleep, soft enable, ctrl window, cfg window 7, reset seen
  logic [6:0] tbl[7] = '{7'h0c, 7'h5c, 7'h4d, 7'h24, 7'h3d, 7'h75, 7'h62};
  wgt_guard dut (.clk_i(clk_i), .rst_i(rst_i), .hsel_i(hsel),
    .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2),
    .hwdata_i(hwdata), .hready_i(hready), .hrdata_o(hrdata),
    .hreadyout_o(hready), .hresp_o(hresp), .guard_mode_cfg_i(mode),
    .cfg_clock_select_i(cclk), .cfg_period_select_i(cper),
    .cfg_window_i(cwin), .cfg_window_select_i(wsel), .sleep_i(sleep),
    .guard_clear_instr_i(clr), .osc_startup_timer_i(osc_startup_timer),
    .guard_reset_o(grst), .irq_o(irq));
  wgt_core_model u_core (.clk_i(clk_i), .rst_i(rst_i), .go_i(go),
    .dly_i(dly), .clr_o(clr));
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  // ----
  // Tasks
  // ----
  task automatic end_sim;
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic cmp(input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      err_count++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic wt;
    for (int k = 0; k < 16; k++) begin
      @(posedge clk_i);
      if (hready === 1'b1) return;
    end
    err_count++;
    end_sim();
  endtask
  task automatic bus(input logic w, input logic [31:0] a,
    input logic [31:0] d);
    @(posedge clk_i);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= a;
    hwrite <= w;
    wt();
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    wt();
  endtask
  task automatic rd(input logic [31:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    bus(1'b0, a, 32'h0000_0000);
  endtask
  // Core clears after a random delay; count reset pulses
  task automatic hit(input logic e);
    int n0;
    n0 = n_rst;
    @(posedge clk_i);
    go <= 1'b1;
    dly <= 4'($urandom_range(7));
    @(posedge clk_i);
    go <= 1'b0;
    repeat (12) @(posedge clk_i);
    @(negedge clk_i);
    cmp({31'h0, e}, 32'(n_rst - n0));
    // Back on the rising edge so later stimulus is driven there
    @(posedge clk_i);
  endtask
  always @(posedge clk_i) begin
    if (rd_dp) cmp(exp_q.pop_front(), hrdata);
    rd_dp <= hsel & htrans[1] & ~hwrite;
    if (grst === 1'b1) n_rst++;
  end
  initial begin
    rst_i = 1'b1;
    {hsel, hwrite, sleep, go, rd_dp, osc_startup_timer} = 6'h00;
    {htrans, mode, dly, cper} = 13'h001f;
    {cclk, cwin, wsel} = 9'h03f;
    haddr = 32'h0000_0000;
    hwdata = 32'h0000_0000;
    void'($urandom(32'hd054158d));
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(32'h0000_0000, 32'h0000_0016);
    rd(32'h0000_0004, 32'h0000_0070);
    rd(32'h0000_0008, 32'h0000_0001);
    rd(32'h0000_0100, 32'h0000_0000);
    r = $urandom;
    bus(1'b1, 32'h0000_0018, r);
    rd(32'h0000_0018, r & 32'h0000_0003);
    $display("test registers done");
    mode <= 2'b11;
    bus(1'b1, 32'h0000_0004, 32'h0000_0000);
    rd(32'h0000_0000, 32'h0000_0016);
    hit(1'b1);
    rd(32'h0000_0008, 32'h0000_0000);
    rd(32'h0000_0010, 32'h0000_0002);
    cmp({31'h0, r[1]}, {31'h0, irq});
    bus(1'b1, 32'h0000_0014, 32'h0000_0003);
    // Status clears at the data-phase edge; look once it has settled
    @(negedge clk_i);
    cmp(32'h0000_0000, {31'h0, irq});
    bus(1'b1, 32'h0000_0008, 32'h0000_0001);
    rd(32'h0000_0008, 32'h0000_0001);
    $display("test window violation done");
    for (i = 0; i < 7; i++) begin
      c = tbl[i];
      mode <= c[6:5];
      sleep <= c[4];
      wsel <= c[2] ? 3'h7 : 3'h0;
      cwin <= c[1] ? 3'h7 : 3'h0;
      bus(1'b1, 32'h0000_0000, {31'h0, c[3]});
      hit(c[0]);
    end
    $display("test modes done");
    bus(1'b1, 32'h0000_0014, 32'h0000_0003);
    mode <= 2'b10;
    sleep <= 1'b0;
    cclk <= 3'h1;
    cper <= 5'h00;
    wsel <= 3'h0;
    cwin <= 3'h7;
    // Control period stays long, so only the config period can fire
    bus(1'b1, 32'h0000_0000, 32'h0000_0016);
    // Start-up timer holds the count at zero for over one tick
    osc_startup_timer <= 1'b1;
    repeat (3300) @(posedge clk_i);
    osc_startup_timer <= 1'b0;
    for (i = 3300; i < 110000 && grst !== 1'b1; i++) @(negedge clk_i);
    if (i >= 110000) begin
      err_count++;
      end_sim();
    end
    // 31 to 32 periods of 3200 cycles after the 3300-cycle hold
    cmp(32'h1, {31'h0, i >= 102500 && i <= 105710});
    rd(32'h0000_000c, 32'h0000_0000);
    rd(32'h0000_0010, 32'h0000_0001);
    $display("test timeout done");
    end_sim();
  end
endmodule
`default_nettype wire

// File: logic/wgt_guard.sv
`timescale 1ns/1ps
`default_nettype none
`include "wgt_regs.svh"

// Summary of operation
// - Time base from 31 kHz or 31.25 kHz
// - Mode 1x: clock from config clock select
// - Mode 01: soft enable, control clock select
// - Mode 11: always active, also asleep
// - Mode 10: active awake, off in sleep
// - Mode 01: active when soft enable set
// - Four modes; 00 always disabled
// - Config period all ones: control period used
// - Other config period overrides control period
// - Reset default period two seconds
// - Clear with window closed causes reset
// - Window from config unless select is 111
// - Top five counter bits decide window open
// - Violation resets, clears flag; firmware sets
// - Counter cleared on listed events and control 0/1 writes
// - Windowed clear needs prior control 0 read arming
module wgt_guard (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  input wire logic [1:0] guard_mode_cfg_i,
  input wire logic [2:0] cfg_clock_select_i,
  input wire logic [4:0] cfg_period_select_i,
  input wire logic [2:0] cfg_window_i,
  input wire logic [2:0] cfg_window_select_i,
  input wire logic sleep_i,
  input wire logic guard_clear_instr_i,
  input wire logic osc_startup_timer_i,
  output logic guard_reset_o,
  output logic irq_o
);

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  logic soft_enable_bit_q;
  logic [4:0] ctrl_period_select_q;
  logic [2:0] ctrl_clock_select_q;
  logic [2:0] ctrl_window_q;
  logic window_violation_flag_q;
  logic [1:0] irq_stat_q;
  logic [1:0] irq_en_q;
  logic armed_q;
  logic sleep_q;
  logic [22:0] cnt_q;
  logic [22:0] cnt_d;
  logic wr_q;
  logic [7:0] addr_q;
  logic [31:0] rdata_q;
  logic reset_q;

  // ---------------------------------------------------------------
  // Bus decode
  // ---------------------------------------------------------------
  wire logic addr_ph_w;
  wire logic rd_ph_w;
  wire logic [7:0] a_w;
  wire logic [31:0] rmux_w;
  wire logic wr_c0_w;
  wire logic wr_c1_w;
  wire logic wr_p0_w;
  wire logic wr_iclr_w;
  wire logic wr_ien_w;
  wire logic rd_c0_w;

  assign addr_ph_w = hsel_i && htrans_i[1] && hready_i;
  assign rd_ph_w = addr_ph_w && !hwrite_i;
  assign a_w = haddr_i[7:0];
  // Arming is taken from the read's address phase
  assign rd_c0_w = rd_ph_w && (a_w == `WGT_OFF_CTRL0) &&
                   (haddr_i[31:8] == 24'h00_0000);
  assign wr_c0_w = wr_q && (addr_q == `WGT_OFF_CTRL0);
  assign wr_c1_w = wr_q && (addr_q == `WGT_OFF_CTRL1);
  assign wr_p0_w = wr_q && (addr_q == `WGT_OFF_POWER_CONTROL_0);
  assign wr_iclr_w = wr_q && (addr_q == `WGT_OFF_ICLR);
  assign wr_ien_w = wr_q && (addr_q == `WGT_OFF_IEN);

  // Unmapped and write-only offsets read as zero
  assign rmux_w =
    (haddr_i[31:8] != 24'h00_0000) ? 32'h0000_0000 :
    (a_w == `WGT_OFF_CTRL0) ? {26'h000_0000, ctrl_period_select_q,
                               soft_enable_bit_q} :
    (a_w == `WGT_OFF_CTRL1) ? {25'h000_0000, ctrl_window_q, 1'b0,
                               ctrl_clock_select_q} :
    (a_w == `WGT_OFF_POWER_CONTROL_0) ? {31'h0000_0000, window_violation_flag_q} :
    (a_w == `WGT_OFF_COUNT) ? {9'h000, cnt_q} :
    (a_w == `WGT_OFF_ISTAT) ? {30'h0000_0000, irq_stat_q} :
    (a_w == `WGT_OFF_IEN) ? {30'h0000_0000, irq_en_q} :
    32'h0000_0000;

  // Zero wait states: read data is latched in the address phase
  assign hrdata_o = rdata_q;
  assign hreadyout_o = 1'b1;
  assign hresp_o = 1'b0;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      wr_q <= 1'b0;
      addr_q <= 8'h00;
      rdata_q <= 32'h0000_0000;
    end else begin
      wr_q <= addr_ph_w && hwrite_i && (haddr_i[31:8] == 24'h00_0000);
      if (addr_ph_w) begin
        addr_q <= a_w;
      end
      if (rd_ph_w) begin
        rdata_q <= rmux_w;
      end
    end
  end

  // ---------------------------------------------------------------
  // Mode and source selection
  // ---------------------------------------------------------------
  wire logic active_w;
  wire logic [2:0] src_w;
  wire logic tick_w;
  wire logic ost_w;

  assign active_w =
    (guard_mode_cfg_i == wgt_pkg::WGT_MODE_ON) ||
    ((guard_mode_cfg_i == wgt_pkg::WGT_MODE_AWAKE) && !sleep_i) ||
    ((guard_mode_cfg_i == wgt_pkg::WGT_MODE_SOFT) &&
     soft_enable_bit_q);

  assign src_w = guard_mode_cfg_i[1] ? cfg_clock_select_i :
                 ctrl_clock_select_q;

  // Oscillator gated off while the timer is disabled to save power
  wgt_tick_gen u_tick (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .run_i(active_w),
    .src_i(src_w),
    .tick_o(tick_w)
  );

  // Start-up timer runs in the oscillator block, another domain
  wgt_sync2 u_ost_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .d_i(osc_startup_timer_i),
    .q_o(ost_w)
  );

  // ---------------------------------------------------------------
  // Period and window
  // ---------------------------------------------------------------
  wire logic [4:0] ps_raw_w;
  wire logic [4:0] ps_w;
  wire logic [23:0] per_w;
  wire logic [22:0] last_w;
  wire logic [4:0] frac_w;
  wire logic [2:0] win_w;
  wire logic [4:0] win_th_w;
  wire logic windowed_w;
  wire logic win_open_w;

  // Config period wins unless left at its all-ones default
  assign ps_raw_w = (cfg_period_select_i == `WGT_PS_CFG_SOFT) ?
                    ctrl_period_select_q :
                    cfg_period_select_i;
  // Codes above the longest period saturate to it
  assign ps_w = (ps_raw_w > `WGT_PS_MAX) ? `WGT_PS_MAX : ps_raw_w;
  // Period is 32 oscillator ticks (about 1 ms) times 2^ps
  assign per_w = (24'h00_0020 << ps_w) - 24'h00_0001;
  assign last_w = per_w[22:0];
  assign frac_w = 5'(cnt_q >> ps_w);

  assign win_w = (cfg_window_select_i == `WGT_WSEL_SOFT) ?
                 ctrl_window_q : cfg_window_i;
  assign win_th_w = (win_w == 3'h6) ? `WGT_WIN_TH_6 :
                    (win_w == 3'h5) ? `WGT_WIN_TH_5 :
                    (win_w == 3'h4) ? `WGT_WIN_TH_4 :
                    (win_w == 3'h3) ? `WGT_WIN_TH_3 :
                    (win_w == 3'h2) ? `WGT_WIN_TH_2 :
                    (win_w == 3'h1) ? `WGT_WIN_TH_1 :
                    (win_w == 3'h0) ? `WGT_WIN_TH_0 : 5'h00;
  assign windowed_w = (win_w != `WGT_WIN_FULL);
  assign win_open_w = (frac_w >= win_th_w);

  // ---------------------------------------------------------------
  // Clear, violation and time-out
  // ---------------------------------------------------------------
  wire logic clr_ok_w;
  wire logic viol_w;
  wire logic timeout_w;
  wire logic sleep_edge_w;
  wire logic wake_edge_w;
  wire logic cnt_clr_w;

  // Unarmed clear is a violation even inside an open window
  assign clr_ok_w = active_w && guard_clear_instr_i &&
                    (!windowed_w || (armed_q && win_open_w));
  assign viol_w = active_w && guard_clear_instr_i && windowed_w &&
                  !(armed_q && win_open_w);
  // At or past the end, so a shortened period expires at the next tick
  assign timeout_w = active_w && tick_w && (cnt_q >= last_w);
  // Any exit from sleep clears, whatever woke the core
  assign sleep_edge_w = sleep_i && !sleep_q;
  assign wake_edge_w = !sleep_i && sleep_q;
  assign cnt_clr_w = clr_ok_w || viol_w || timeout_w || sleep_edge_w ||
                     wake_edge_w || !active_w || ost_w ||
                     wr_c0_w || wr_c1_w;
  // Clears take priority over a tick in the same cycle
  assign cnt_d = cnt_clr_w ? 23'h00_0000 :
                 tick_w ? cnt_q + 23'h00_0001 : cnt_q;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_q <= 23'h00_0000;
      sleep_q <= 1'b0;
      reset_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      sleep_q <= sleep_i;
      reset_q <= timeout_w || viol_w;
    end
  end

  assign guard_reset_o = reset_q;

  // ---------------------------------------------------------------
  // Control registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      soft_enable_bit_q <= 1'b0;
      ctrl_period_select_q <= `WGT_PS_RESET;
      ctrl_clock_select_q <= `WGT_CS_RESET;
      ctrl_window_q <= `WGT_WIN_RESET;
    end else begin
      if (wr_c0_w) begin
        soft_enable_bit_q <= hwdata_i[`WGT_C0_SEN];
        ctrl_period_select_q <= hwdata_i[`WGT_C0_PS_LSB +: 5];
      end
      if (wr_c1_w) begin
        ctrl_clock_select_q <= hwdata_i[`WGT_C1_CS_LSB +: 3];
        ctrl_window_q <= hwdata_i[`WGT_C1_WIN_LSB +: 3];
      end
    end
  end

  // Arming lasts until the next clear instruction
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      armed_q <= 1'b0;
    end else if (guard_clear_instr_i) begin
      armed_q <= 1'b0;
    end else if (rd_c0_w) begin
      armed_q <= 1'b1;
    end
  end

  // Hardware clear beats a firmware set in the same cycle
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      window_violation_flag_q <= 1'b1;
    end else if (viol_w) begin
      window_violation_flag_q <= 1'b0;
    end else if (wr_p0_w && hwdata_i[`WGT_P0_WV]) begin
      window_violation_flag_q <= 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // Interrupt status
  // ---------------------------------------------------------------
  wire logic [1:0] ev_w;
  wire logic [1:0] clr_w;

  assign ev_w = {viol_w, timeout_w};
  assign clr_w = wr_iclr_w ? hwdata_i[1:0] : 2'b00;

  // New events win over a clear in the same cycle
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      irq_stat_q <= 2'b00;
      irq_en_q <= 2'b00;
    end else begin
      irq_stat_q <= (irq_stat_q & ~clr_w) | ev_w;
      if (wr_ien_w) begin
        irq_en_q <= hwdata_i[1:0];
      end
    end
  end

  assign irq_o = |(irq_stat_q & irq_en_q);

endmodule

`default_nettype wire

// File: logic/wgt_pkg.sv
`default_nettype none

package wgt_pkg;

  typedef enum logic [1:0] {
    WGT_MODE_OFF,
    WGT_MODE_SOFT,
    WGT_MODE_AWAKE,
    WGT_MODE_ON
  } wgt_mode_e;

  typedef enum logic [2:0] {
    WGT_SRC_LF,
    WGT_SRC_MF
  } wgt_src_e;

endpackage

`default_nettype wire

// File: logic/wgt_regs.svh
`ifndef WGT_REGS_SVH
`define WGT_REGS_SVH

// ---------------------------------------------------------------
// Timing
// ---------------------------------------------------------------
`define WGT_CLK_HZ 100000000
`define WGT_LF_HZ 31000
`define WGT_MF_HZ 31250
`define WGT_LF_DIV (`WGT_CLK_HZ / `WGT_LF_HZ)
`define WGT_MF_DIV (`WGT_CLK_HZ / `WGT_MF_HZ)
`define WGT_DIV_W 12

// ---------------------------------------------------------------
// Register offsets
// ---------------------------------------------------------------
`define WGT_OFF_CTRL0 8'h00
`define WGT_OFF_CTRL1 8'h04
`define WGT_OFF_POWER_CONTROL_0 8'h08
`define WGT_OFF_COUNT 8'h0c
`define WGT_OFF_ISTAT 8'h10
`define WGT_OFF_ICLR 8'h14
`define WGT_OFF_IEN 8'h18

// ---------------------------------------------------------------
// Fields and reset values
// ---------------------------------------------------------------
`define WGT_C0_SEN 0
`define WGT_C0_PS_LSB 1
`define WGT_C1_CS_LSB 0
`define WGT_C1_WIN_LSB 4
`define WGT_P0_WV 0
`define WGT_IRQ_TMO 0
`define WGT_IRQ_VIOL 1
`define WGT_PS_RESET 5'h0b
`define WGT_PS_MAX 5'h12
`define WGT_PS_CFG_SOFT 5'h1f
`define WGT_WSEL_SOFT 3'h7
`define WGT_WIN_FULL 3'h7
`define WGT_CS_RESET 3'h0
`define WGT_WIN_RESET 3'h7

// Window closed fraction, in 32nds of the period
`define WGT_WIN_TH_6 5'h08
`define WGT_WIN_TH_5 5'h0c
`define WGT_WIN_TH_4 5'h10
`define WGT_WIN_TH_3 5'h14
`define WGT_WIN_TH_2 5'h18
`define WGT_WIN_TH_1 5'h1a
`define WGT_WIN_TH_0 5'h1c

`endif

// File: logic/wgt_sync2.sv
`timescale 1ns/1ps
`default_nettype none

module wgt_sync2 (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic d_i,
  output logic q_o
);

  logic meta_q;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      meta_q <= 1'b0;
      q_o <= 1'b0;
    end else begin
      meta_q <= d_i;
      q_o <= meta_q;
    end
  end

endmodule

`default_nettype wire

// File: logic/wgt_tick_gen.sv
`timescale 1ns/1ps
`default_nettype none
`include "wgt_regs.svh"

module wgt_tick_gen (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic run_i,
  input wire logic [2:0] src_i,
  output logic tick_o
);

  // ---------------------------------------------------------------
  // Oscillator emulated as enable pulse from the system clock
  // ---------------------------------------------------------------
  logic [`WGT_DIV_W-1:0] div_q;
  logic [`WGT_DIV_W-1:0] div_d;
  wire logic [`WGT_DIV_W-1:0] last_w;
  wire logic wrap_w;

  // Unknown selects fall back to the low-frequency source
  assign last_w = (src_i == 3'(wgt_pkg::WGT_SRC_MF)) ?
                  `WGT_DIV_W'(`WGT_MF_DIV - 1) :
                  `WGT_DIV_W'(`WGT_LF_DIV - 1);
  assign wrap_w = (div_q >= last_w);
  assign div_d = (!run_i || wrap_w) ? '0 : div_q + `WGT_DIV_W'(1);

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      div_q <= '0;
      tick_o <= 1'b0;
    end else begin
      div_q <= div_d;
      tick_o <= run_i && wrap_w;
    end
  end

endmodule

`default_nettype wire
